// >>> rtl/mbf_pkg.sv
// ****************************************************************
// Shared constants, types and helpers for the frame field sequencer
// ****************************************************************
package mbf_pkg;

  // ****************************************************************
  // Field geometry
  // ****************************************************************
  localparam int CTL_W = 4;            // Control code width
  localparam int BYTE_W = 8;           // Byte-count and data width
  localparam int SH_W = BYTE_W + 1;    // Widest field: byte plus parity
  localparam int CNT_W = 9;            // Holds a remaining count of 256
  localparam int TRY_W = 6;            // Holds attempts up to the frame limit
  localparam int BIT_W = 4;            // Bit position inside one field
  localparam int DIR_BIT = 3;          // Control bit that picks the direction
  localparam int FRAME_MAX_BYTES = 32; // Data bytes allowed per frame

  localparam logic [BIT_W-1:0] CTL_LAST = 4'h4;  // Index of control parity bit
  localparam logic [BIT_W-1:0] BYTE_LAST = 4'h8; // Index of byte parity bit
  localparam logic [CNT_W-1:0] LEN_ZERO_BYTES = 9'h100; // Count 00 means 256
  localparam logic [CTL_W-1:0] CTL_PAD = 4'h0;   // Fill below a control field

  // Bus levels: wired-AND, zero is the dominant level
  localparam logic ACK_LVL = 1'b0;   // Acceptance level of an acknowledge slot
  localparam logic IDLE_LVL = 1'b1;  // Released bus level

  // ****************************************************************
  // Control codes
  // ****************************************************************
  localparam logic [CTL_W-1:0] CC_RD_STATUS = 4'h0;
  localparam logic [CTL_W-1:0] CC_RD_DATA_LOCK = 4'h3;
  localparam logic [CTL_W-1:0] CC_RD_LOCK_LO = 4'h4;
  localparam logic [CTL_W-1:0] CC_RD_LOCK_HI = 4'h5;
  localparam logic [CTL_W-1:0] CC_RD_STATUS_UNLOCK = 4'h6;
  localparam logic [CTL_W-1:0] CC_RD_DATA = 4'h7;
  localparam logic [CTL_W-1:0] CC_WR_CMD_LOCK = 4'hA;
  localparam logic [CTL_W-1:0] CC_WR_DATA_LOCK = 4'hB;
  localparam logic [CTL_W-1:0] CC_WR_CMD = 4'hE;
  localparam logic [CTL_W-1:0] CC_WR_DATA = 4'hF;

  // Decoded function of a control code
  typedef enum logic [3:0] {
    MBF_FN_UNDEF = 4'b0000,
    MBF_FN_RD_STATUS = 4'b0001,
    MBF_FN_RD_DATA_LOCK = 4'b0010,
    MBF_FN_RD_LOCK_LO = 4'b0011,
    MBF_FN_RD_LOCK_HI = 4'b0100,
    MBF_FN_RD_STATUS_UNLOCK = 4'b0101,
    MBF_FN_RD_DATA = 4'b0110,
    MBF_FN_WR_CMD_LOCK = 4'b0111,
    MBF_FN_WR_DATA_LOCK = 4'b1000,
    MBF_FN_WR_CMD = 4'b1001,
    MBF_FN_WR_DATA = 4'b1010
  } mbf_func_t;

  // Sequencer states
  typedef enum logic [2:0] {
    MBF_S_IDLE = 3'b000,
    MBF_S_CTL = 3'b001,
    MBF_S_CTL_ACK = 3'b010,
    MBF_S_LEN = 3'b011,
    MBF_S_LEN_ACK = 3'b100,
    MBF_S_DAT = 3'b101,
    MBF_S_DAT_ACK = 3'b110
  } mbf_state_t;

  // Frame context handed over by the address stage
  typedef struct packed {
    logic is_master;                            // We hold the bus
    logic broadcast;                            // Broadcast frame
    logic locked;                               // Unit is locked
    logic [CTL_W-1:0] control_code_register;    // Code to send as master
  } mbf_ctx_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Even parity bit: one when the field holds an odd count of ones
  function automatic logic mbf_parity(input logic [BYTE_W-1:0] v);
    return ^v;
  endfunction : mbf_parity

  // Control code to function
  function automatic mbf_func_t mbf_decode(input logic [CTL_W-1:0] c);
    mbf_func_t f;
    f = MBF_FN_UNDEF;
    unique case (c)
      CC_RD_STATUS: f = MBF_FN_RD_STATUS;
      CC_RD_DATA_LOCK: f = MBF_FN_RD_DATA_LOCK;
      CC_RD_LOCK_LO: f = MBF_FN_RD_LOCK_LO;
      CC_RD_LOCK_HI: f = MBF_FN_RD_LOCK_HI;
      CC_RD_STATUS_UNLOCK: f = MBF_FN_RD_STATUS_UNLOCK;
      CC_RD_DATA: f = MBF_FN_RD_DATA;
      CC_WR_CMD_LOCK: f = MBF_FN_WR_CMD_LOCK;
      CC_WR_DATA_LOCK: f = MBF_FN_WR_DATA_LOCK;
      CC_WR_CMD: f = MBF_FN_WR_CMD;
      CC_WR_DATA: f = MBF_FN_WR_DATA;
      default: f = MBF_FN_UNDEF;
    endcase
    return f;
  endfunction : mbf_decode

  // Whether a slave may accept a code in its current lock state
  function automatic logic mbf_legal(input logic [CTL_W-1:0] c, input logic locked);
    logic lock_rd;
    lock_rd = (c == CC_RD_LOCK_LO) || (c == CC_RD_LOCK_HI);
    if (mbf_decode(c) == MBF_FN_UNDEF) begin
      return 1'b0;
    end else if (locked) begin
      return lock_rd || (c == CC_RD_STATUS);
    end else begin
      return !lock_rd;
    end
  endfunction : mbf_legal

  // Byte-count field to a number of bytes
  function automatic logic [CNT_W-1:0] mbf_len_bytes(input logic [BYTE_W-1:0] v);
    return (v == '0) ? LEN_ZERO_BYTES : {1'b0, v};
  endfunction : mbf_len_bytes

endpackage : mbf_pkg

// >>> rtl/mbf_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bus pin synchroniser: three stages, a change counts once the
// second and third stage agree
// ****************************************************************
module mbf_pin_sync #(
  parameter logic RESET_LVL = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Raw pin and filtered level
  input wire logic pin_i,
  output logic lvl_o
);

  logic s1_reg; // Metastability catcher, read by s2 only
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic lvl_next;

  // Level moves only when the two settled stages agree
  always_comb begin
    lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
  end

  // Registers; bus idles released, so reset to that level
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_reg <= RESET_LVL;
      s2_reg <= RESET_LVL;
      s3_reg <= RESET_LVL;
      lvl_reg <= RESET_LVL;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign lvl_o = lvl_reg;

endmodule : mbf_pin_sync
`default_nettype wire

// >>> rtl/mbf_frame_fields.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Slave acks control only on good parity, support
// - Individual master needs control ack, else standby
// - Broadcast master ignores control ack slot
// - Decode read codes 0,3,4,5,6,7
// - Decode write codes A,B,E,F; rest undefined
// - Control bit 3 picks field direction
// - Locked slave accepts status and lock-address reads
// - Unlocked slave rejects both lock-address reads
// - Master sends code from control_code_register
// - Byte count 01-FF literal, 00 means 256
// - Byte count driven per control bit 3
// - Slave acks good master byte count only
// - Master acks good slave byte count only
// - Data byte, parity, ack; broadcast writes only, broadcast read codes not refused
// - Slave acks data on good parity, empty buffer
// - Master resends unacked byte within frame limit
// - Master sends next byte after ack, within limit
// - Broadcast slave stops on bad or blocked byte
// - Reading master strobes sync for each data field bit
// - Reading master nacks bad/blocked byte, rereads it
// - Reading master acks good byte, reads next
// - Parity bit makes total ones even
// - Acknowledge is zero, rejection leaves one
// - At most 32 data bytes per frame
module mbf_frame_fields
  import mbf_pkg::*;
#(
  parameter int MAX_BYTES = mbf_pkg::FRAME_MAX_BYTES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Hand-over from the address stage
  input wire logic frame_go,
  input wire mbf_pkg::mbf_ctx_t ctx,
  // Bit timing from the slot generator
  input wire logic slot_tick,
  // Bus pin, open drain
  input wire logic bus_pin_i,
  output logic bus_pin_o,
  output logic bus_pin_oe,
  output logic sync_o,
  // Local user side
  input wire logic func_ok,
  input wire logic [mbf_pkg::BYTE_W-1:0] len_to_send,
  input wire logic [mbf_pkg::BYTE_W-1:0] tx_byte,
  output logic tx_next,
  output logic [mbf_pkg::BYTE_W-1:0] byte_buffer,
  output logic rx_full,
  input wire logic rx_pop,
  // Frame status
  output logic [mbf_pkg::CTL_W-1:0] code_o,
  output mbf_pkg::mbf_func_t func_o,
  output logic [mbf_pkg::CNT_W-1:0] remain_o,
  output logic busy,
  output logic frame_done,
  output logic frame_err
);
  import mbf_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  mbf_state_t state_reg, state_next;
  mbf_ctx_t ctx_reg, ctx_next;                 // Context latched per frame
  logic [BIT_W-1:0] cnt_reg, cnt_next;         // Bit within field
  logic [SH_W-1:0] sh_reg, sh_next;            // Shift register, MSB on bus
  logic [CTL_W-1:0] code_reg, code_next;       // Control code of this frame
  mbf_func_t func_reg, func_next;              // Its decoded function
  logic [CNT_W-1:0] len_reg, len_next;         // Bytes still to move
  logic [TRY_W-1:0] tries_reg, tries_next;     // Byte attempts in this frame
  logic ack_drv_reg, ack_drv_next;             // We pull the ack slot low
  logic acc_reg, acc_next;                     // We accepted the last byte
  logic [BYTE_W-1:0] buf_reg, buf_next;        // One-byte receive buffer
  logic full_reg, full_next;
  logic oe_reg, oe_next;                       // Registered pin drive
  logic sync_reg, sync_next;
  logic tx_next_reg, tx_next_next;
  logic done_reg, done_next;
  logic err_reg, err_next;

  // ****************************************************************
  // Derived terms
  // ****************************************************************
  logic bus_lvl;         // Filtered bus level
  logic master;
  logic bcast;
  logic m2s;             // Master sends byte count and data
  logic driver;          // We drive the current count or data field
  logic [SH_W-1:0] sh_in;
  logic last_bit;
  logic ack_seen;
  logic par_ok;
  logic [TRY_W-1:0] tries_inc;
  logic limit_ok;        // Another attempt still fits in the frame

  mbf_pin_sync #(
    .RESET_LVL(IDLE_LVL)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_i(bus_pin_i),
    .lvl_o(bus_lvl)
  );

  assign master = ctx_reg.is_master;
  assign bcast = ctx_reg.broadcast;
  assign m2s = code_reg[DIR_BIT];
  assign driver = (master == m2s);
  assign sh_in = {sh_reg[SH_W-2:0], bus_lvl};
  assign last_bit = slot_tick &&
    (cnt_reg == ((state_reg == MBF_S_CTL) ? CTL_LAST : BYTE_LAST));
  assign ack_seen = (bus_lvl == ACK_LVL);
  assign par_ok = (state_reg == MBF_S_CTL) ? !(^sh_in[CTL_W:0]) : !(^sh_in);
  assign tries_inc = tries_reg + 1'b1;
  assign limit_ok = (tries_inc < TRY_W'(MAX_BYTES));

  // ****************************************************************
  // Sequencer: next values
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    ctx_next = ctx_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    code_next = code_reg;
    func_next = func_reg;
    len_next = len_reg;
    tries_next = tries_reg;
    ack_drv_next = ack_drv_reg;
    acc_next = acc_reg;
    buf_next = buf_reg;
    full_next = full_reg && !rx_pop;
    tx_next_next = 1'b0;
    done_next = 1'b0;
    err_next = 1'b0;
    sync_next = 1'b0;
    unique case (state_reg)
      // Wait for the address stage to finish
      MBF_S_IDLE: begin
        if (frame_go) begin
          ctx_next = ctx;
          cnt_next = '0;
          tries_next = '0;
          ack_drv_next = 1'b0;
          state_next = MBF_S_CTL;
          // Master shifts out its own code, a slave listens
          sh_next = ctx.is_master ?
            {ctx.control_code_register,
             mbf_parity({CTL_PAD, ctx.control_code_register}), CTL_PAD}
            : '1;
        end
      end
      // Control code and parity
      MBF_S_CTL: begin
        if (slot_tick) begin
          sh_next = sh_in;
          cnt_next = cnt_reg + 1'b1;
        end
        if (last_bit) begin
          code_next = master ? ctx_reg.control_code_register : sh_in[CTL_W:1];
          func_next = mbf_decode(code_next);
          cnt_next = '0;
          if (master) begin
            state_next = MBF_S_CTL_ACK;
          end else if (par_ok && func_ok && mbf_legal(sh_in[CTL_W:1], ctx_reg.locked)) begin
            state_next = MBF_S_CTL_ACK;
            ack_drv_next = !bcast;
          end else begin
            state_next = MBF_S_IDLE;
            err_next = 1'b1;
          end
        end
      end
      // Acknowledge after the control field
      MBF_S_CTL_ACK: begin
        if (slot_tick) begin
          ack_drv_next = 1'b0;
          sh_next = '1;
          err_next = master && !bcast && !ack_seen;
          state_next = err_next ? MBF_S_IDLE : MBF_S_LEN;
        end
      end
      // Byte count or data: one bit per tick
      MBF_S_LEN, MBF_S_DAT: begin
        if (slot_tick) begin
          sh_next = sh_in;
          cnt_next = cnt_reg + 1'b1;
          sync_next = (state_reg == MBF_S_DAT) && master && !m2s;
        end
        if (last_bit) begin
          cnt_next = '0;
          ack_drv_next = 1'b0;
          if (state_reg == MBF_S_LEN) begin
            len_next = mbf_len_bytes(sh_in[SH_W-1:1]);
            if (driver) begin
              state_next = MBF_S_LEN_ACK;
            end else if (par_ok) begin
              state_next = MBF_S_LEN_ACK;
              ack_drv_next = !bcast;
            end else begin
              state_next = MBF_S_IDLE;
              err_next = 1'b1;
            end
          end else begin
            state_next = MBF_S_DAT_ACK;
            if (!driver) begin
              // Buffer must be empty before this byte lands
              acc_next = par_ok && !full_reg;
              ack_drv_next = acc_next && !bcast;
              if (acc_next) begin
                buf_next = sh_in[SH_W-1:1];
                full_next = 1'b1;
              end else if (bcast) begin
                state_next = MBF_S_IDLE;
                err_next = 1'b1;
              end
            end
          end
        end
      end
      // Acknowledge after the byte count
      MBF_S_LEN_ACK: begin
        if (slot_tick) begin
          ack_drv_next = 1'b0;
          sh_next = '1;
          err_next = driver && !bcast && !ack_seen;
          state_next = err_next ? MBF_S_IDLE : MBF_S_DAT;
        end
      end
      // Acknowledge after a data byte: advance, retry or finish
      MBF_S_DAT_ACK: begin
        if (slot_tick) begin
          ack_drv_next = 1'b0;
          sh_next = '1;
          tries_next = tries_inc;
          // Broadcast slots are ignored by the sender
          if (driver ? (bcast || ack_seen) : acc_reg) begin
            tx_next_next = driver;
            len_next = len_reg - 1'b1;
            if ((len_next == '0) || !limit_ok) begin
              state_next = MBF_S_IDLE;
              done_next = 1'b1;
            end else begin
              state_next = MBF_S_DAT;
            end
          end else if (limit_ok) begin
            state_next = MBF_S_DAT;
          end else begin
            state_next = MBF_S_IDLE;
            err_next = 1'b1;
          end
        end
      end
      default: state_next = MBF_S_IDLE;
    endcase
    // Driver loads its field as the field opens, reloading until the first tick
    if (driver && (cnt_next == '0) && (state_next inside {MBF_S_LEN, MBF_S_DAT})) begin
      sh_next = (state_next == MBF_S_LEN) ?
        {len_to_send, mbf_parity(len_to_send)} :
        {tx_byte, mbf_parity(tx_byte)};
    end
    // Pin pulls low for a zero bit we drive or for our acknowledge
    unique case (state_next)
      MBF_S_CTL: oe_next = ctx_next.is_master && !sh_next[SH_W-1];
      MBF_S_LEN, MBF_S_DAT: oe_next = driver && !sh_next[SH_W-1];
      MBF_S_CTL_ACK, MBF_S_LEN_ACK, MBF_S_DAT_ACK: oe_next = ack_drv_next;
      default: oe_next = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer: registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= MBF_S_IDLE;
      ctx_reg <= '0;
      cnt_reg <= '0;
      sh_reg <= '1;
      code_reg <= '0;
      func_reg <= MBF_FN_UNDEF;
      len_reg <= '0;
      tries_reg <= '0;
      ack_drv_reg <= 1'b0;
      acc_reg <= 1'b0;
      buf_reg <= '0;
      full_reg <= 1'b0;
      oe_reg <= 1'b0;
      sync_reg <= 1'b0;
      tx_next_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctx_reg <= ctx_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      code_reg <= code_next;
      func_reg <= func_next;
      len_reg <= len_next;
      tries_reg <= tries_next;
      ack_drv_reg <= ack_drv_next;
      acc_reg <= acc_next;
      buf_reg <= buf_next;
      full_reg <= full_next;
      oe_reg <= oe_next;
      sync_reg <= sync_next;
      tx_next_reg <= tx_next_next;
      done_reg <= done_next;
      err_reg <= err_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus_pin_o = ACK_LVL;       // Open drain: only ever pulls low
  assign bus_pin_oe = oe_reg;
  assign sync_o = sync_reg;
  assign tx_next = tx_next_reg;
  assign byte_buffer = buf_reg;
  assign rx_full = full_reg;
  assign code_o = code_reg;
  assign func_o = func_reg;
  assign remain_o = len_reg;
  assign busy = (state_reg != MBF_S_IDLE);
  assign frame_done = done_reg;
  assign frame_err = err_reg;

endmodule : mbf_frame_fields
`default_nettype wire

// >>> tb/mbf_far_unit.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Far bus unit model
// ****
module mbf_far_unit (
  // Clock, reset, slot timing
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic slot_tick,
  // Slot pattern, first slot in bit 63
  input wire logic load,
  input wire logic [63:0] pat,
  // Pull on the wired-AND bus
  output logic drive_low
);
  logic [63:0] pat_reg; // Slots still to play
  // One bit per slot; the bench lays out fields MSB first, parity, then
  // ack. A read slave shows its bit in each strobed slot
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pat_reg <= '1;
    end else if (load) begin
      pat_reg <= pat;
    end else if (slot_tick) begin
      pat_reg <= {pat_reg[62:0], 1'b1}; // Released after the pattern
    end
  end
  assign drive_low = !pat_reg[63]; // Zero dominates
endmodule : mbf_far_unit
`default_nettype wire

// >>> tb/mbf_frame_fields_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module mbf_frame_fields_chk
  import mbf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Inputs
  input wire logic frame_go,
  input wire mbf_pkg::mbf_ctx_t ctx,
  input wire logic slot_tick,
  input wire logic rx_pop,
  // Outputs
  input wire logic bus_pin_o,
  input wire logic bus_pin_oe,
  input wire logic sync_o,
  input wire logic rx_full,
  input wire logic [mbf_pkg::CTL_W-1:0] code_o,
  input wire logic busy,
  input wire logic frame_done,
  input wire logic frame_err
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Master takes a frame while idle
  sequence s_mstart;
    frame_go && !busy && ctx.is_master;
  endsequence
  // Frame ends either way
  sequence s_end;
    frame_done || frame_err;
  endsequence
  // First bit is the code MSB from the master's register
  property p_first;
    s_mstart |=> bus_pin_oe == !$past(ctx.control_code_register[DIR_BIT]);
  endproperty
  pin_drive_a: assert property (bus_pin_o == ACK_LVL)
    else $error("pin data not low");
  first_bit_a: assert property (p_first)
    else $error("first control bit wrong");
  end_idle_a: assert property (s_end |-> !busy)
    else $error("busy after frame end");
  end_pulse_a: assert property (s_end |=> !frame_done && !frame_err)
    else $error("end pulse too long");
  end_one_a: assert property (!(frame_done && frame_err))
    else $error("done and error together");
  // Idle unit leaves the bus released
  idle_quiet_a: assert property (!busy [*2] |-> !bus_pin_oe)
    else $error("idle unit pulls bus");
  // Bus drive changes only at a slot boundary or at frame start
  slot_hold_a: assert property ($changed(bus_pin_oe) |-> $past(slot_tick) || $past(frame_go))
    else $error("drive changed inside slot");
  sync_slot_a: assert property (sync_o |-> $past(slot_tick) && !code_o[DIR_BIT])
    else $error("stray sync pulse");
  pop_clear_a: assert property (rx_full && rx_pop && !slot_tick |=> !rx_full)
    else $error("buffer not freed");
endmodule : mbf_frame_fields_chk
bind mbf_frame_fields mbf_frame_fields_chk u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .frame_go(frame_go), .ctx(ctx),
  .slot_tick(slot_tick), .rx_pop(rx_pop), .bus_pin_o(bus_pin_o),
  .bus_pin_oe(bus_pin_oe), .sync_o(sync_o), .rx_full(rx_full),
  .code_o(code_o), .busy(busy), .frame_done(frame_done), .frame_err(frame_err)
);
`default_nettype wire

// >>> tb/mbf_frame_fields_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Frame field bench
// ****
module mbf_frame_fields_tb;
  import mbf_pkg::*;
  // Design inputs
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic frame_go = 1'b0;
  mbf_ctx_t ctx = '0;
  logic slot_tick = 1'b0;
  logic func_ok = 1'b1;
  logic [7:0] len_to_send = 8'h02;
  logic [7:0] tx_byte = 8'h00;
  logic rx_pop = 1'b0;
  // Design outputs
  logic bus_pin_o, bus_pin_oe, sync_o, tx_next, rx_full, busy, frame_done, frame_err;
  logic [7:0] byte_buffer;
  logic [3:0] code_o;
  mbf_func_t func_o;
  logic [8:0] remain_o;
  // Far unit, pattern and wired-AND bus with pull-up
  logic far_low;
  logic load = 1'b0;
  logic [63:0] pat = '1;
  logic [63:0] dv; // Slots in which the design pulled low
  int pp, bad_count, compares, n_done, n_err, n_tx, n_sync;
  wire logic bus_pin_i = !bus_pin_oe && !far_low;
  mbf_frame_fields #(.MAX_BYTES(3)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .frame_go(frame_go), .ctx(ctx),
    .slot_tick(slot_tick), .bus_pin_i(bus_pin_i), .bus_pin_o(bus_pin_o),
    .bus_pin_oe(bus_pin_oe), .sync_o(sync_o), .func_ok(func_ok),
    .len_to_send(len_to_send), .tx_byte(tx_byte), .tx_next(tx_next),
    .byte_buffer(byte_buffer), .rx_full(rx_full), .rx_pop(rx_pop),
    .code_o(code_o), .func_o(func_o), .remain_o(remain_o), .busy(busy),
    .frame_done(frame_done), .frame_err(frame_err)
  );
  mbf_far_unit u_far (
    .clk_sys(clk_sys), .rstn(rstn), .slot_tick(slot_tick), .load(load),
    .pat(pat), .drive_low(far_low)
  );
  initial begin
    forever #12.5 clk_sys = !clk_sys;
  end
  // Count pulses; old values are read at the edge, so no race
  always @(posedge clk_sys) begin
    if (frame_done === 1'b1) n_done++;
    if (frame_err === 1'b1) n_err++;
    if (tx_next === 1'b1) n_tx++;
    if (sync_o === 1'b1) n_sync++;
  end
  function automatic logic par(input logic [7:0] v);
    return ^v;
  endfunction : par
  // Codes a slave may take in its lock state
  function automatic logic lg(input logic [3:0] c, input logic lk);
    case (c)
      4'h0: return 1'b1;
      4'h4, 4'h5: return lk;
      4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hE, 4'hF: return !lk;
      default: return 1'b0;
    endcase
  endfunction : lg
  // Bits the design drove in n slots from s, first slot on top
  function automatic logic [8:0] fld(input int s, input int n);
    logic [8:0] r;
    r = '0;
    for (int k = 0; k < n; k++) begin
      r = {r[7:0], !dv[s + k]};
    end
    return r;
  endfunction : fld
  task automatic put(input logic [9:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      pat[63 - pp] = v[k];
      pp++;
    end
  endtask : put
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Reset, start a frame, give nt slots spaced 9 clocks apart
  task automatic frame(input logic [6:0] c, input int nt);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    {n_done, n_err, n_tx, n_sync} = '0;
    ctx <= c;
    frame_go <= 1'b1;
    load <= 1'b1;
    @(posedge clk_sys);
    frame_go <= 1'b0;
    load <= 1'b0;
    dv = '0;
    for (int i = 0; i < nt; i++) begin
      repeat (7) @(posedge clk_sys);
      @(negedge clk_sys);
      dv[i] = bus_pin_oe;
      @(posedge clk_sys);
      slot_tick <= 1'b1;
      @(posedge clk_sys);
      slot_tick <= 1'b0;
    end
    // Pattern is cleared only long after the far unit has loaded it
    pat = '1;
    pp = 0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : frame
  task automatic conclude();
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    #1_000_000;
    bad_count++;
    conclude();
  end
  initial begin
    logic [3:0] c;
    logic [7:0] d;
    logic b;
    logic ok;
    void'($urandom(32'h3006));
    repeat (5) @(posedge clk_sys);
    // Slave control ack over all codes and lock states, random parity and support
    for (int i = 0; i < 32; i++) begin
      c = i[3:0];
      b = ($urandom % 5) == 0;
      ok = ($urandom % 4) != 0;
      put({c, par(c) ^ b, 1'b1}, 6);
      @(posedge clk_sys);
      func_ok <= ok;
      frame({2'b00, i[4], 4'h0}, 6);
      chk("ctl_ack", lg(c, i[4]) && ok && !b, dv[5]);
    end
    // Slave write; bad count parity; broadcast with bad data parity
    for (int m = 0; m < 3; m++) begin
      d = $urandom;
      put({4'hF, par(4'hF), 1'b1}, 6);
      put({8'h02, par(8'h02) ^ (m == 1), 1'b1}, 10);
      put({d, par(d) ^ (m == 2), 1'b1}, 10);
      put({~d, par(~d), 1'b1}, 10);
      @(posedge clk_sys);
      func_ok <= 1'b1;
      frame({1'b0, m == 2, 5'h00}, 36);
      chk("ctl_ack", m != 2, dv[5]);
      chk("len_ack", m == 0, dv[15]);
      chk("abort", m != 0, n_err);
      if (m == 0) begin
        chk("dat_ack", 1, dv[25]);
        chk("buffer", d, byte_buffer);
        chk("full_ack", 0, dv[35]);
        @(posedge clk_sys);
        rx_pop <= 1'b1;
        @(posedge clk_sys);
        rx_pop <= 1'b0;
        @(negedge clk_sys);
        chk("pop", 0, rx_full);
      end
    end
    // Master write: retry on nack; control nack; broadcast ignores acks
    for (int m = 0; m < 3; m++) begin
      d = $urandom;
      put({5'h1F, m != 0}, 6);
      put({9'h1FF, m == 2}, 10);
      put(10'h3FF, 10);
      put({9'h1FF, m == 2}, 10);
      put(10'h3FE, 10);
      @(posedge clk_sys);
      tx_byte <= d;
      frame({1'b1, m == 2, 5'h0F}, 46);
      chk("ctl_bits", {4'hF, par(4'hF)}, fld(0, 5));
      if (m == 1) begin
        chk("no_len", 0, dv[14:6]);
        chk("abort", 1, n_err);
      end else begin
        chk("len_bits", {8'h02, par(8'h02)}, fld(6, 9));
        chk("byte0", {d, par(d)}, fld(16, 9));
        chk("byte1", {d, par(d)}, fld(26, 9));
        chk("sent", 2, n_tx);
        chk("done", 1, n_done);
      end
      if (m == 0) chk("byte2", {d, par(d)}, fld(36, 9));
    end
    // Master read: count parity, sync per bit, reread on bad parity
    for (int m = 0; m < 3; m++) begin
      d = $urandom;
      put(6'h3E, 6);
      put({8'h01, par(8'h01) ^ (m == 1), 1'b1}, 10);
      put({d, par(d) ^ (m == 2), 1'b1}, 10);
      put({d, par(d), 1'b1}, 10);
      frame(7'h47, 36);
      chk("len_ack", m != 1, dv[15]);
      if (m != 1) begin
        chk("dat_ack", m == 0, dv[25]);
        chk("buffer", d, byte_buffer);
        chk("syncs", m == 2 ? 18 : 9, n_sync);
      end
      if (m == 2) chk("reread", 1, dv[35]);
    end
    // Slave read: we drive count and data, the far master acks both
    d = $urandom;
    put({4'h7, par(4'h7), 1'b1}, 6);
    put(10'h3FE, 10);
    put(10'h3FE, 10);
    @(posedge clk_sys);
    len_to_send <= 8'h01;
    tx_byte <= d;
    frame(7'h00, 26);
    chk("ctl_ack", 1, dv[5]);
    chk("len_out", {8'h01, par(8'h01)}, fld(6, 9));
    chk("dat_out", {d, par(d)}, fld(16, 9));
    chk("slv_done", 1, n_done);
    conclude();
  end
endmodule : mbf_frame_fields_tb
`default_nettype wire
